//--- rtl/touch_pkg.sv
/*
  Constants, register map and phase encoding of the touch acquisition unit.
  Assumes a byte-addressed classic Wishbone slave with 32-bit data and one clock.
*/
package touch_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_PIN_SELECT = 8'h04;
  localparam logic [7:0] OFS_MODE_LOW = 8'h08;
  localparam logic [7:0] OFS_MODE_HIGH = 8'h0c;
  localparam logic [7:0] OFS_TIMING = 8'h10;
  localparam logic [7:0] OFS_DRIVE = 8'h14;
  localparam logic [7:0] OFS_DETECT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h3c;
  localparam logic [7:0] OFS_STATUS_CLEAR = 8'h40;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h44;
  localparam logic [7:0] OFS_SPREAD = 8'h60;
  localparam logic [7:0] OFS_BASE_COUNT = 8'h6c;
  localparam logic [7:0] OFS_CURR_COUNT = 8'h70;
  localparam logic [7:0] OFS_CMP_SIX = 8'h98;
  localparam logic [7:0] OFS_CMP_SEVEN = 8'h9c;
  localparam logic [7:0] OFS_FEATURES = 8'hf8;
  localparam logic [7:0] OFS_VERSION = 8'hfc;

  // Values after reset and writable bits
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_WMASK = 32'h0000_0001;
  localparam logic [31:0] PIN_SELECT_WMASK = 32'h0000_011f;
  localparam logic [31:0] MODE_WMASK = 32'h0001_ffff;
  localparam logic [31:0] TIMING_WMASK = 32'hffff_ffff;
  localparam logic [31:0] DRIVE_WMASK = 32'h33ff_ffff;
  localparam logic [31:0] DETECT_WMASK = 32'h000f_ffff;
  localparam logic [31:0] SPREAD_WMASK = 32'h0000_ffff;
  localparam logic [31:0] FULL_WMASK = 32'hffff_ffff;
  // Arbitrary identification values
  localparam logic [31:0] FEATURE_VALUE = 32'h0000_0011;
  localparam logic [31:0] VERSION_VALUE = 32'h0000_0100;

  // Field positions
  localparam int EN_BIT = 0;
  localparam int SOFT_RESET_BIT = 7;
  localparam int AUTONOMOUS_TOUCH_ENABLE_BIT = 8;
  localparam int PAIR_LSB = 0;
  localparam int DIV_LSB = 16;
  localparam int CHARGE_LSB = 8;
  localparam int SETTLE_LSB = 0;
  localparam int DISCH_SCALE_LSB = 28;
  localparam int SYNC_BIT = 25;
  localparam int SPREAD_BIT = 24;
  localparam int DISCH_LSB = 16;
  localparam int MAX_LSB = 0;
  localparam int FILTER_LSB = 16;
  localparam int RELEASE_LSB = 8;
  localparam int TOUCH_LSB = 0;
  localparam int DEV_LSB = 0;
  localparam int TOUCHED_BIT = 16;

  // Sticky event bits
  localparam int EV_DONE = 0;
  localparam int EV_TOUCH = 1;
  localparam int EV_RELEASE = 2;
  localparam int EV_W = 3;
  localparam int NUM_PAIRS = 17;

  typedef enum logic [2:0] {P_IDLE, P_SYNC, P_DISCH, P_CHARGE, P_SETTLE, P_DONE} phase_t;

endpackage : touch_pkg

//--- rtl/touch_prescaler.sv
/*
  Sampling prescaler: one-cycle tick every 2(div+1) clocks, or a sawtooth
  spread around that divisor. Assumes div and max_dev stay put while run is high.
*/
`timescale 1ns/1ps
`default_nettype none
module touch_prescaler (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic spread,
  input wire logic [15:0] div,
  input wire logic [15:0] max_dev,
  // Sample enable
  output logic tick
);

  typedef struct packed {
    logic [17:0] cnt;
    logic [17:0] step;
    logic tick;
  } pre_state_t;

  pre_state_t st;
  pre_state_t next;
  logic [17:0] nominal;
  logic [17:0] divisor;

  assign nominal = 18'({div, 1'b0}) + 18'h2;
  assign divisor = nominal - 18'(max_dev) + st.step;

  always_comb begin
    next = st;
    next.tick = 1'b0;
    if (!run) begin
      next.cnt = 18'h0;
      next.step = 18'(max_dev);
    end else if (st.cnt + 18'h1 >= divisor) begin
      next.tick = 1'b1;
      next.cnt = 18'h0;
      if (!spread) begin
        next.step = 18'(max_dev);
      end else if (st.step >= 18'({max_dev, 1'b0})) begin
        next.step = 18'h0;
      end else begin
        next.step = st.step + 18'h1;
      end
    end else begin
      next.cnt = st.cnt + 18'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next;
    end
  end

  assign tick = st.tick;

  ////////////////////////////////////////////////////////////////////////////
  fixed_divisor_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.tick && $past(run && !spread)) |-> $past(st.cnt) + 18'h1 >= $past(nominal))
    else $error("fixed divisor tick came before 2(div+1) clocks");
  sawtooth_span_a: assert property (@(posedge ref_clk) disable iff (rst)
    run |-> st.step <= 18'({max_dev, 1'b0}))
    else $error("spread step left the sawtooth span");

endmodule : touch_prescaler
`default_nettype wire

//--- rtl/touch_acquisition_config.sv
/*
  Touch acquisition unit: Wishbone register file, autonomous sensor sequencer,
  detection filter and pair-mode decode. Assumes sense_b_in and sync_in are
  asynchronous pins; the pad logic resolves pin level from out and oe.
*/
// How it works
// - Soft-reset write resets unit; bit reads zero.
// - Control bit zero enables or disables unit.
// - Autonomous enable runs acquisition and detection.
// - Pair index selects the A/B pin pair.
// - High/low mode bits form each pair's group.
// - Sample tick is clock over 2(div+1).
// - Charge lasts the programmed sample ticks.
// - Settle wait follows each charge transfer.
// - Discharge precedes charging for programmed ticks.
// - Discharge length is shifted by scale field.
// - Sync bit waits for falling sync edge.
// - Spread bit selects varying pulse timing.
// - Maximum count caps one acquisition's bursts.
// - Touch after filter-count consecutive detects; nonzero.
// - Release threshold decides the sensor released.
// - Touch threshold decides the sensor touched.
// - Spread divisor sweeps sawtooth around nominal.
`timescale 1ns/1ps
`default_nettype none
module touch_acquisition_config (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq,
  // Sense pins
  output logic [16:0] sense_a_out,
  output logic [16:0] sense_a_oe,
  input wire logic [16:0] sense_b_in,
  output logic [16:0] sense_b_out,
  output logic [16:0] sense_b_oe,
  input wire logic sync_in,
  // Pair groups and detector state
  output logic [16:0] pair_group_a,
  output logic [16:0] pair_group_b,
  output logic [16:0] pair_group_matrix,
  output logic touch_detected
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] control;
    logic [31:0] pin_select;
    logic [31:0] mode_low;
    logic [31:0] mode_high;
    logic [31:0] timing;
    logic [31:0] drive;
    logic [31:0] detect;
    logic [31:0] spread_cfg;
    logic [31:0] cmp_six;
    logic [31:0] cmp_seven;
    logic [touch_pkg::EV_W-1:0] status;
    logic [touch_pkg::EV_W-1:0] irq_en;
    logic irq;
    logic [17:0] sy1;
    logic [17:0] sy2;
    logic [17:0] sy3;
    logic [17:0] filt;
    touch_pkg::phase_t phase;
    logic [15:0] tmr;
    logic [15:0] count;
    logic [4:0] pair;
    logic [15:0] base;
    logic base_ok;
    logic [3:0] filt_cnt;
    logic touched;
    logic [16:0] a_out;
    logic [16:0] a_oe;
    logic [16:0] b_out;
    logic [16:0] b_oe;
    logic [16:0] grp_a;
    logic [16:0] grp_b;
    logic [16:0] grp_m;
  } acq_state_t;

  acq_state_t st;
  acq_state_t next;
  logic tick;
  logic req;
  logic wr;
  logic soft_reset;
  logic sync_fall;
  logic [15:0] delta;
  logic [15:0] disc_len;
  logic [7:0] chg_len;
  logic [7:0] stl_len;
  logic [15:0] max_cnt;
  logic [3:0] filter;
  logic [7:0] rel_thr;
  logic [7:0] tch_thr;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                        input logic [3:0] sel, input logic [31:0] wmask);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return (old & ~(m & wmask)) | (din & m & wmask);
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Field views
  assign chg_len = st.timing[touch_pkg::CHARGE_LSB +: 8];
  assign stl_len = st.timing[touch_pkg::SETTLE_LSB +: 8];
  assign disc_len = 16'({8'h00, st.drive[touch_pkg::DISCH_LSB +: 8]} <<
                        st.drive[touch_pkg::DISCH_SCALE_LSB +: 2]);
  assign max_cnt = st.drive[touch_pkg::MAX_LSB +: 16];
  assign filter = st.detect[touch_pkg::FILTER_LSB +: 4];
  assign rel_thr = st.detect[touch_pkg::RELEASE_LSB +: 8];
  assign tch_thr = st.detect[touch_pkg::TOUCH_LSB +: 8];
  assign delta = (st.base > st.count) ? st.base - st.count : 16'h0000;
  assign sync_fall = st.filt[17] && (st.sy2[17] == st.sy3[17]) && !st.sy3[17];

  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr = req && wb_we_i;
  assign soft_reset = wr && (wb_adr_i[7:2] == touch_pkg::OFS_CONTROL[7:2]) && wb_sel_i[0] &&
                      wb_dat_i[touch_pkg::SOFT_RESET_BIT];

  // Divider halts between acquisitions so each one starts on a fresh period
  touch_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .run(st.control[touch_pkg::EN_BIT] && st.pin_select[touch_pkg::AUTONOMOUS_TOUCH_ENABLE_BIT] &&
         st.phase != touch_pkg::P_IDLE),
    .spread(st.drive[touch_pkg::SPREAD_BIT]),
    .div(st.timing[touch_pkg::DIV_LSB +: 16]),
    .max_dev(st.spread_cfg[touch_pkg::DEV_LSB +: 16]),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [touch_pkg::EV_W-1:0] ev;
    logic [16:0] onehot;
    ev = '0;
    onehot = '0;
    next = st;
    next.ack = req;
    // Pin synchronisers; a level counts once stages two and three agree
    next.sy1 = {sync_in, sense_b_in};
    next.sy2 = st.sy1;
    next.sy3 = st.sy2;
    next.filt = (st.sy3 & ~(st.sy2 ^ st.sy3)) | (st.filt & (st.sy2 ^ st.sy3));
    // Register reads; unmapped words read zero
    if (req && !wb_we_i) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        touch_pkg::OFS_CONTROL: next.rdata = st.control;
        touch_pkg::OFS_PIN_SELECT: next.rdata = st.pin_select;
        touch_pkg::OFS_MODE_LOW: next.rdata = st.mode_low;
        touch_pkg::OFS_MODE_HIGH: next.rdata = st.mode_high;
        touch_pkg::OFS_TIMING: next.rdata = st.timing;
        touch_pkg::OFS_DRIVE: next.rdata = st.drive;
        touch_pkg::OFS_DETECT: next.rdata = st.detect;
        touch_pkg::OFS_STATUS: next.rdata = 32'(st.status);
        touch_pkg::OFS_IRQ_ENABLE: next.rdata = 32'(st.irq_en);
        touch_pkg::OFS_SPREAD: next.rdata = st.spread_cfg;
        touch_pkg::OFS_BASE_COUNT: next.rdata = 32'(st.base);
        touch_pkg::OFS_CURR_COUNT: next.rdata = {15'h0000, st.touched, st.count};
        touch_pkg::OFS_CMP_SIX: next.rdata = st.cmp_six;
        touch_pkg::OFS_CMP_SEVEN: next.rdata = st.cmp_seven;
        touch_pkg::OFS_FEATURES: next.rdata = touch_pkg::FEATURE_VALUE;
        touch_pkg::OFS_VERSION: next.rdata = touch_pkg::VERSION_VALUE;
        default: next.rdata = 32'h0000_0000;
      endcase
    end
    // Register writes; unmapped words ignore the data
    if (wr) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        touch_pkg::OFS_CONTROL: next.control = merge(st.control, wb_dat_i, wb_sel_i,
                                                     touch_pkg::CONTROL_WMASK);
        touch_pkg::OFS_PIN_SELECT: next.pin_select = merge(st.pin_select, wb_dat_i, wb_sel_i,
                                                           touch_pkg::PIN_SELECT_WMASK);
        touch_pkg::OFS_MODE_LOW: next.mode_low = merge(st.mode_low, wb_dat_i, wb_sel_i,
                                                       touch_pkg::MODE_WMASK);
        touch_pkg::OFS_MODE_HIGH: next.mode_high = merge(st.mode_high, wb_dat_i, wb_sel_i,
                                                         touch_pkg::MODE_WMASK);
        touch_pkg::OFS_TIMING: next.timing = merge(st.timing, wb_dat_i, wb_sel_i,
                                                   touch_pkg::TIMING_WMASK);
        touch_pkg::OFS_DRIVE: next.drive = merge(st.drive, wb_dat_i, wb_sel_i,
                                                 touch_pkg::DRIVE_WMASK);
        touch_pkg::OFS_DETECT: next.detect = merge(st.detect, wb_dat_i, wb_sel_i,
                                                   touch_pkg::DETECT_WMASK);
        touch_pkg::OFS_STATUS_CLEAR: next.status = st.status & ~wb_dat_i[touch_pkg::EV_W-1:0];
        touch_pkg::OFS_IRQ_ENABLE: next.irq_en = wb_dat_i[touch_pkg::EV_W-1:0];
        touch_pkg::OFS_SPREAD: next.spread_cfg = merge(st.spread_cfg, wb_dat_i, wb_sel_i,
                                                       touch_pkg::SPREAD_WMASK);
        touch_pkg::OFS_CMP_SIX: next.cmp_six = merge(st.cmp_six, wb_dat_i, wb_sel_i,
                                                     touch_pkg::FULL_WMASK);
        touch_pkg::OFS_CMP_SEVEN: next.cmp_seven = merge(st.cmp_seven, wb_dat_i, wb_sel_i,
                                                         touch_pkg::FULL_WMASK);
        default: next.control = st.control;
      endcase
    end
    // Sequencer
    if (!st.control[touch_pkg::EN_BIT] || !st.pin_select[touch_pkg::AUTONOMOUS_TOUCH_ENABLE_BIT]) begin
      next.phase = touch_pkg::P_IDLE;
    end else begin
      unique case (st.phase)
        touch_pkg::P_IDLE: begin
          next.pair = st.pin_select[touch_pkg::PAIR_LSB +: 5];
          next.count = 16'h0000;
          next.tmr = disc_len;
          next.phase = st.drive[touch_pkg::SYNC_BIT] ? touch_pkg::P_SYNC : touch_pkg::P_DISCH;
        end
        touch_pkg::P_SYNC: begin
          if (sync_fall) begin
            next.phase = touch_pkg::P_DISCH;
          end
        end
        touch_pkg::P_DISCH: begin
          if (tick) begin
            if (st.tmr <= 16'h0001) begin
              next.phase = touch_pkg::P_CHARGE;
              next.tmr = 16'(chg_len);
            end else begin
              next.tmr = st.tmr - 16'h0001;
            end
          end
        end
        touch_pkg::P_CHARGE: begin
          if (tick) begin
            if (st.tmr <= 16'h0001) begin
              next.phase = touch_pkg::P_SETTLE;
              next.tmr = 16'(stl_len);
            end else begin
              next.tmr = st.tmr - 16'h0001;
            end
          end
        end
        touch_pkg::P_SETTLE: begin
          if (tick) begin
            if (st.tmr <= 16'h0001) begin
              next.count = st.count + 16'h0001;
              if (st.filt[st.pair] || next.count >= max_cnt) begin
                next.phase = touch_pkg::P_DONE;
              end else begin
                next.phase = touch_pkg::P_CHARGE;
                next.tmr = 16'(chg_len);
              end
            end else begin
              next.tmr = st.tmr - 16'h0001;
            end
          end
        end
        touch_pkg::P_DONE: begin
          ev[touch_pkg::EV_DONE] = 1'b1;
          next.phase = touch_pkg::P_IDLE;
          if (!st.base_ok) begin
            next.base = st.count;
            next.base_ok = 1'b1;
          end else if (delta > 16'(tch_thr)) begin
            next.filt_cnt = (st.filt_cnt >= filter) ? filter : st.filt_cnt + 4'h1;
            if (!st.touched && next.filt_cnt >= filter) begin
              next.touched = 1'b1;
              ev[touch_pkg::EV_TOUCH] = 1'b1;
            end
          end else begin
            next.filt_cnt = 4'h0;
            if (st.touched && delta <= 16'(rel_thr)) begin
              next.touched = 1'b0;
              ev[touch_pkg::EV_RELEASE] = 1'b1;
            end
          end
        end
        default: next.phase = touch_pkg::P_IDLE;
      endcase
    end
    // Events set after the clear, so a same-cycle event survives
    next.status = next.status | ev;
    // Pin drive follows the phase being entered
    onehot = 17'(17'h00001 << next.pair);
    next.a_oe = (next.phase == touch_pkg::P_DISCH || next.phase == touch_pkg::P_CHARGE) ? onehot : '0;
    next.a_out = (next.phase == touch_pkg::P_CHARGE) ? onehot : '0;
    next.b_oe = next.a_oe;
    next.b_out = '0;
    next.grp_a = st.mode_low[16:0] & ~st.mode_high[16:0];
    next.grp_b = ~st.mode_low[16:0] & st.mode_high[16:0];
    next.grp_m = st.mode_low[16:0] & st.mode_high[16:0];
    next.irq = |(next.status & next.irq_en);
    // Soft reset returns everything but the bus answer and the pin samplers
    if (soft_reset) begin
      next = '0;
      next.ack = 1'b1;
      next.sy1 = {sync_in, sense_b_in};
      next.sy2 = st.sy1;
      next.sy3 = st.sy2;
      next.filt = st.filt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign irq = st.irq;
  assign sense_a_out = st.a_out;
  assign sense_a_oe = st.a_oe;
  assign sense_b_out = st.b_out;
  assign sense_b_oe = st.b_oe;
  assign pair_group_a = st.grp_a;
  assign pair_group_b = st.grp_b;
  assign pair_group_matrix = st.grp_m;
  assign touch_detected = st.touched;

  ////////////////////////////////////////////////////////////////////////////
  sequence ctrl_write_s(bit val);
    wr && wb_adr_i[7:2] == touch_pkg::OFS_CONTROL[7:2] && wb_sel_i[0] && wb_dat_i[touch_pkg::EN_BIT] == val;
  endsequence

  soft_reset_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    soft_reset |=> !st.control[touch_pkg::EN_BIT] ##1 st.phase == touch_pkg::P_IDLE)
    else $error("soft reset left unit enabled or running");
  soft_reset_regs_a: assert property (@(posedge ref_clk) disable iff (rst)
    soft_reset |=> st.timing == touch_pkg::REG_RESET && st.drive == touch_pkg::REG_RESET && !st.touched)
    else $error("soft reset kept register contents");
  enable_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (ctrl_write_s(1'b0) ##0 !soft_reset) |=> !st.control[touch_pkg::EN_BIT] ##1 st.phase == touch_pkg::P_IDLE)
    else $error("clearing enable did not stop the unit");
  disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
    !st.control[touch_pkg::EN_BIT] |=> sense_a_oe == '0 && sense_b_oe == '0)
    else $error("disabled unit drives sense pins");
  autonomous_touch_enable_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    !st.pin_select[touch_pkg::AUTONOMOUS_TOUCH_ENABLE_BIT] |=> st.phase == touch_pkg::P_IDLE)
    else $error("acquisition ran with autonomous enable clear");
  pair_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    st.phase == touch_pkg::P_CHARGE |-> sense_a_out == 17'(17'h00001 << st.pair) && sense_a_oe == sense_a_out)
    else $error("charge drives the wrong pair");
  pair_mode_a: assert property (@(posedge ref_clk) disable iff (rst)
    !soft_reset |=> pair_group_b == $past(~st.mode_low[16:0] & st.mode_high[16:0]))
    else $error("pair group decode wrong");
  charge_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($changed(st.phase) && st.phase == touch_pkg::P_CHARGE) |-> st.tmr == 16'(chg_len))
    else $error("charge length not loaded");
  settle_load_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($changed(st.phase) && st.phase == touch_pkg::P_SETTLE) |-> st.tmr == 16'(stl_len))
    else $error("settle length not loaded");
  discharge_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.phase == touch_pkg::P_DISCH && !tick && st.control[touch_pkg::EN_BIT] &&
     st.pin_select[touch_pkg::AUTONOMOUS_TOUCH_ENABLE_BIT] && !soft_reset) |=> st.phase == touch_pkg::P_DISCH)
    else $error("discharge ended without a sample tick");
  discharge_scale_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.phase == touch_pkg::P_IDLE && !st.drive[touch_pkg::SYNC_BIT] && !soft_reset &&
     st.control[touch_pkg::EN_BIT] && st.pin_select[touch_pkg::AUTONOMOUS_TOUCH_ENABLE_BIT]) |=> st.tmr == $past(disc_len))
    else $error("discharge time not shifted length");
  sync_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.phase == touch_pkg::P_SYNC && !sync_fall) |=> st.phase inside {touch_pkg::P_SYNC, touch_pkg::P_IDLE})
    else $error("acquisition started without sync falling edge");
  max_count_a: assert property (@(posedge ref_clk) disable iff (rst)
    (st.phase == touch_pkg::P_SETTLE && tick && st.tmr <= 16'h0001 && 16'(st.count + 16'h0001) >= max_cnt &&
     st.control[touch_pkg::EN_BIT] && st.pin_select[touch_pkg::AUTONOMOUS_TOUCH_ENABLE_BIT] && !soft_reset)
     |=> st.phase == touch_pkg::P_DONE)
    else $error("acquisition passed the maximum count");
  filter_touch_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(st.touched) |-> st.filt_cnt >= filter)
    else $error("touch reported before filter count");
  touch_thresh_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(st.touched) |-> $past(delta) > 16'($past(tch_thr)))
    else $error("touch reported below threshold");
  release_thresh_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(st.touched) && !$past(soft_reset)) |-> $past(delta) <= 16'($past(rel_thr)))
    else $error("release reported above threshold");

endmodule : touch_acquisition_config
`default_nettype wire

//--- sim/touch_sensor_model.sv
/* Electrode model: comparator on pin B trips after TRIP charge pulses.
   Assumes A drive low with oe high means discharge. */
`timescale 1ns/1ps
`default_nettype none
module touch_sensor_model #(
  parameter int TRIP = 5
) (
  // Pins
  input wire logic ref_clk,
  input wire logic [16:0] sense_a_out,
  input wire logic [16:0] sense_a_oe,
  output logic [16:0] sense_b_in
);
  logic [16:0] prev = '0;
  int charges[17];
  always @(posedge ref_clk) begin
    for (int n = 0; n < 17; n++) begin
      if (sense_a_oe[n] && !sense_a_out[n]) charges[n] = 0;
      else if (sense_a_out[n] && !prev[n]) charges[n]++;
      sense_b_in[n] <= charges[n] >= TRIP;
    end
    prev <= sense_a_out;
  end
endmodule : touch_sensor_model
`default_nettype wire

//--- sim/tb_top.sv
/* Bench: register model, pair decode, soft reset, one acquisition with irq.
   Assumes touch_sensor_model on the pins; sync toggles every 16 cycles and gates the touch test. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq, touched, sync = 1;
  logic [7:0] adr = 0;
  logic [31:0] dat = 0, rdat, v, seed = 32'hdb681883;
  logic [16:0] a_out, a_oe, b_in, b_out, b_oe, g_a, g_b, g_m, lo, hi;
  int fail_count = 0, tests_run = 0, n, pair;
  logic [7:0] offs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [31:0] msk[7] = '{touch_pkg::CONTROL_WMASK, touch_pkg::PIN_SELECT_WMASK, touch_pkg::MODE_WMASK,
    touch_pkg::MODE_WMASK, touch_pkg::TIMING_WMASK, touch_pkg::DRIVE_WMASK, touch_pkg::DETECT_WMASK};
  always #2 ref_clk = ~ref_clk;
  // Sync line: a falling edge every 32 cycles
  always begin
    repeat (16) @(posedge ref_clk);
    sync <= ~sync;
  end
  touch_sensor_model sensor (.ref_clk(ref_clk), .sense_a_out(a_out), .sense_a_oe(a_oe), .sense_b_in(b_in));
  touch_acquisition_config dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
    .sense_a_out(a_out), .sense_a_oe(a_oe), .sense_b_in(b_in), .sense_b_out(b_out), .sense_b_oe(b_oe),
    .sync_in(sync),
    .pair_group_a(g_a), .pair_group_b(g_b), .pair_group_matrix(g_m), .touch_detected(touched));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("register", e, rdat);
  endtask : rd
  task automatic close_out;
    $display("Compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(offs[i], 32'h0);
    for (int i = 0; i < 7; i++) begin
      v = $random(seed) & ~32'h80;
      if (i == 6) v[16] = 1'b1;
      wb(1'b1, offs[i], v);
      rd(offs[i], v & msk[i]);
      if (i == 2) lo = v[16:0];
      if (i == 3) hi = v[16:0];
    end
    chk("group a", lo & ~hi, g_a);
    chk("group b", ~lo & hi, g_b);
    chk("matrix", lo & hi, g_m);
    rd(8'h20, 32'h0);
    $display("Test registers done");
    wb(1'b1, 8'h00, 32'h81);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    chk("a drive", 32'h0, a_oe);
    $display("Test soft reset done");
    pair = {$random(seed)} % 17;
    wb(1'b1, touch_pkg::OFS_TIMING, 32'h0001_0101);
    wb(1'b1, touch_pkg::OFS_DRIVE, 32'h0000_0064);
    wb(1'b1, touch_pkg::OFS_DETECT, 32'h0001_0000);
    wb(1'b1, touch_pkg::OFS_IRQ_ENABLE, 32'h1);
    wb(1'b1, 8'h04, 32'h100 | pair);
    wb(1'b1, 8'h00, 32'h1);
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("irq", 32'h1, irq);
    rd(touch_pkg::OFS_BASE_COUNT, 32'h5);
    chk("touched", 32'h0, touched);
    wb(1'b1, 8'h00, 32'h0);
    rd(touch_pkg::OFS_STATUS, 32'h1);
    chk("a drive", 32'h0, a_oe);
    wb(1'b1, touch_pkg::OFS_IRQ_ENABLE, 32'h0);
    rd(touch_pkg::OFS_IRQ_ENABLE, 32'h0);
    chk("irq masked", 32'h0, irq);
    wb(1'b1, touch_pkg::OFS_STATUS_CLEAR, 32'h7);
    wb(1'b1, touch_pkg::OFS_IRQ_ENABLE, 32'h1);
    rd(touch_pkg::OFS_STATUS, 32'h0);
    chk("irq cleared", 32'h0, irq);
    $display("Test acquisition done");
    wb(1'b1, touch_pkg::OFS_DETECT, 32'h0002_0101);
    wb(1'b1, touch_pkg::OFS_SPREAD, 32'h0000_0001);
    wb(1'b1, touch_pkg::OFS_DRIVE, 32'h1302_0003);
    wb(1'b1, 8'h00, 32'h1);
    n = 0;
    while (touched !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("touched", 32'h1, touched);
    rd(touch_pkg::OFS_STATUS, 32'h3);
    wb(1'b1, touch_pkg::OFS_DRIVE, 32'h1302_0064);
    n = 0;
    while (touched !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("released", 32'h0, touched);
    rd(touch_pkg::OFS_STATUS, 32'h7);
    wb(1'b1, 8'h00, 32'h0);
    rd(touch_pkg::OFS_BASE_COUNT, 32'h5);
    chk("b drive", 32'h0, b_oe | b_out);
    $display("Test touch done");
    close_out();
  end
endmodule : tb_top
`default_nettype wire
